// File: dse_formatter.sv
// wrapper and compatibility descriptor checker with encapsulation registers
// Behaviour
// - ip datagrams use encapsulation code 04
// - plain modules use download code 01
// - carouseled modules use carousel code 0d
// - streams accept only codes 01 or 0b
// - model and version fields reported
//
// Added by the designer: register access over Avalon-MM and the register addresses.
module dse_formatter
  import dse_pkg::*;
#(
  parameter logic [23:0] OWN_OUI = 24'h00a5a5  // value is arbitrary
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // descriptor byte stream
  input  dse_in_s          in_i,
  output logic             in_ready_o,
  output dse_out_s         out_o
);
  typedef enum logic [11:0] {
    ST_TAG   = 12'h001,
    ST_WLEN  = 12'h002,
    ST_TLEN  = 12'h004,
    ST_CNT   = 12'h008,
    ST_KIND  = 12'h010,
    ST_DLEN  = 12'h020,
    ST_SPEC  = 12'h040,
    ST_OUI   = 12'h080,
    ST_MODEL = 12'h100,
    ST_VER   = 12'h200,
    ST_SUB   = 12'h400,
    ST_SKIP  = 12'h800
  } dse_state_e;

  function automatic logic [7:0] enc_expect(input dse_class_e c);
    case (c)
      CLS_IP:       enc_expect = ENC_IP;
      CLS_MODULE:   enc_expect = ENC_DOWNLOAD;
      CLS_CAROUSEL: enc_expect = ENC_CAROUSEL;
      default:      enc_expect = ENC_DOWNLOAD;
    endcase
  endfunction

  function automatic logic enc_ok(input dse_class_e c, input logic [7:0] k);
    enc_ok = (k == enc_expect(c)) || (c == CLS_STREAM && k == ENC_PIPE);
  endfunction

  dse_state_e  st_q, st_d;
  logic [1:0]  idx_q, idx_d;
  logic [7:0]  wrem_q, wlen_q, drem_q, drem_d;
  logic [15:0] acc_q, cnt_q, seen_q, seen_d, cnt_now, model_q, ver_q;
  logic        first_q, ours_q, ferr_q, bad, end_bad, endbyte, payload;
  logic        take, two;
  logic [7:0]  b;
  logic        en_q, err_q, mism_q, ack_q;
  logic [7:0]  frames_q, errs_q;
  logic [15:0] exp_model_q;
  dse_class_e  cls_q;
  logic [7:0]  code_q;
  logic [31:0] rdata_q, rdata_d;
  dse_out_s    out_q;
  logic        wr_ack, mism_set, frame_end, frame_bad;

  assign b          = in_i.data;
  assign take       = in_i.valid && en_q;
  assign in_ready_o = 1'b1;
  assign two        = (idx_q == 2'd1);
  assign payload    = !(st_q == ST_TAG || st_q == ST_WLEN);
  assign endbyte    = payload && (wrem_q == 8'd1);
  assign cnt_now    = (st_q == ST_CNT) ? {acc_q[7:0], b} : cnt_q;

  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q + 2'd1;
    drem_d = drem_q - 8'd1;
    seen_d = seen_q;
    bad    = 1'b0;
    case (st_q)
      ST_TAG: begin
        bad   = (b != WRAP_TAG);
        st_d  = ST_WLEN;
        idx_d = 2'd0;
      end
      ST_WLEN: begin
        bad   = (b == 8'h00);
        st_d  = bad ? ST_TAG : ST_TLEN;
        idx_d = 2'd0;
      end
      ST_TLEN: begin
        if (two) begin
          bad   = ({acc_q[7:0], b} > TOTAL_MAX) ||
                  ({acc_q[7:0], b} != {8'h00, wlen_q} - TOTAL_HDR);
          st_d  = ST_CNT;
          idx_d = 2'd0;
        end
      end
      ST_CNT: begin
        if (two) begin
          st_d = ST_KIND;
        end
      end
      ST_KIND: begin
        bad    = first_q && (b != KIND_SYSSW);
        seen_d = seen_q + 16'd1;
        st_d   = ST_DLEN;
      end
      ST_DLEN: begin
        drem_d = b;
        if (first_q) begin
          bad  = (b < FIRST_LEN);
          st_d = ST_SPEC;
        end else begin
          st_d = (b == 8'h00) ? ST_KIND : ST_SKIP;
        end
      end
      ST_SPEC: begin
        bad   = (b != SPEC_OUI);
        st_d  = ST_OUI;
        idx_d = 2'd0;
      end
      ST_OUI: begin
        if (idx_q == 2'd2) begin
          st_d  = ST_MODEL;
          idx_d = 2'd0;
        end
      end
      ST_MODEL: begin
        if (two) begin
          st_d  = ST_VER;
          idx_d = 2'd0;
        end
      end
      ST_VER: begin
        if (two) begin
          st_d = ST_SUB;
        end
      end
      ST_SUB: begin
        // own oui forbids private sub-descriptors, so length is exact
        bad  = ours_q && ((b != 8'h00) || (drem_q != 8'd1));
        st_d = (drem_q == 8'd1) ? ST_KIND : ST_SKIP;
      end
      ST_SKIP: begin
        if (drem_q == 8'd1) begin
          st_d = ST_KIND;
        end
      end
      default: begin
        st_d = ST_TAG;
      end
    endcase
    // a frame must close on a descriptor boundary with the declared count
    end_bad = endbyte && ((st_d != ST_KIND) || (seen_d != cnt_now));
  end

  assign frame_end = take && (endbyte || (st_q == ST_WLEN && b == 8'h00));
  assign frame_bad = ferr_q || bad || end_bad;

  // parser state
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !en_q) begin
      st_q    <= ST_TAG;
      idx_q   <= 2'd0;
      wrem_q  <= 8'd0;
      wlen_q  <= 8'd0;
      drem_q  <= 8'd0;
      acc_q   <= 16'h0000;
      cnt_q   <= 16'h0000;
      seen_q  <= 16'h0000;
      first_q <= 1'b1;
      ours_q  <= 1'b0;
      ferr_q  <= 1'b0;
    end else if (take) begin
      st_q   <= endbyte ? ST_TAG : st_d;
      idx_q  <= idx_d;
      acc_q  <= {acc_q[7:0], b};
      seen_q <= seen_d;
      if (st_q == ST_WLEN) begin
        wrem_q <= b;
        wlen_q <= b;
      end else if (payload) begin
        wrem_q <= wrem_q - 8'd1;
      end
      if (st_q == ST_CNT && two) begin
        cnt_q <= cnt_now;
      end
      if (st_q == ST_DLEN || st_q == ST_SPEC || st_q == ST_OUI ||
          st_q == ST_MODEL || st_q == ST_VER || st_q == ST_SUB ||
          st_q == ST_SKIP) begin
        drem_q <= drem_d;
      end
      if (st_q == ST_OUI && idx_q == 2'd2) begin
        ours_q <= ({acc_q[15:0], b} == OWN_OUI);
      end
      if (st_q == ST_SUB) begin
        first_q <= 1'b0;
      end
      if (frame_end) begin
        ferr_q  <= 1'b0;
        first_q <= 1'b1;
        seen_q  <= 16'h0000;
      end else begin
        ferr_q <= frame_bad;
      end
    end
  end

  // wrapped bytes forwarded unchanged; err on last tells consumer to drop
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      out_q <= '0;
    end else begin
      out_q.valid <= take && payload;
      out_q.data  <= b;
      out_q.last  <= take && endbyte;
      out_q.err   <= take && endbyte && frame_bad;
    end
  end
  assign out_o = out_q;

  // reported model and version of the first descriptor
  assign mism_set = take && st_q == ST_MODEL && two &&
                    ({acc_q[7:0], b} != exp_model_q);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      model_q <= 16'h0000;
      ver_q   <= 16'h0000;
    end else if (take && two) begin
      if (st_q == ST_MODEL) begin
        model_q <= {acc_q[7:0], b};
      end
      if (st_q == ST_VER) begin
        ver_q <= {acc_q[7:0], b};
      end
    end
  end

  // bus handshake: one wait cycle, then answer
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_ack            = avs_write_i && ack_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address_i)
      REG_CTRL:    rdata_d[CTRL_EN_BIT] = en_q;
      REG_ENCAP: begin
        rdata_d[1:0]          = cls_q;
        rdata_d[15:8]         = code_q;
        rdata_d[ENC_VALID_BIT] = enc_ok(cls_q, code_q);
        rdata_d[31:24]        = enc_expect(cls_q);
      end
      REG_STATUS: begin
        rdata_d[ST_ERR_BIT]  = err_q;
        rdata_d[ST_MISM_BIT] = mism_q;
        rdata_d[15:8]        = frames_q;
        rdata_d[23:16]       = errs_q;
      end
      REG_MODEL:   rdata_d = {model_q, exp_model_q};
      REG_VERSION: rdata_d = {16'h0000, ver_q};
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata_o = rdata_q;

  // software-written control
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      en_q        <= EN_RST;
      cls_q       <= CLS_IP;
      code_q      <= 8'h00;
      exp_model_q <= MODEL_RST;
    end else if (wr_ack) begin
      if (avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
        en_q <= avs_writedata_i[CTRL_EN_BIT];
      end
      if (avs_address_i == REG_ENCAP) begin
        if (avs_byteenable_i[0]) begin
          cls_q <= dse_class_e'(avs_writedata_i[1:0]);
        end
        if (avs_byteenable_i[1]) begin
          code_q <= avs_writedata_i[15:8];
        end
      end
      if (avs_address_i == REG_MODEL) begin
        if (avs_byteenable_i[0]) begin
          exp_model_q[7:0] <= avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
          exp_model_q[15:8] <= avs_writedata_i[15:8];
        end
      end
    end
  end

  // sticky err and mismatch bits, write one to clear; a new event beats the clear; frame and error counters clear only at reset and wrap at 8 bits
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      err_q    <= 1'b0;
      mism_q   <= 1'b0;
      frames_q <= 8'h00;
      errs_q   <= 8'h00;
    end else begin
      if (frame_end && frame_bad) begin
        err_q <= 1'b1;
      end else if (wr_ack && avs_address_i == REG_STATUS &&
                   avs_byteenable_i[0] && avs_writedata_i[ST_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      if (mism_set) begin
        mism_q <= 1'b1;
      end else if (wr_ack && avs_address_i == REG_STATUS &&
                   avs_byteenable_i[0] && avs_writedata_i[ST_MISM_BIT]) begin
        mism_q <= 1'b0;
      end
      if (frame_end) begin
        frames_q <= frames_q + 8'd1;
      end
      if (frame_end && frame_bad) begin
        errs_q <= errs_q + 8'd1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ip_code_a: assert property (avs_read_i && !ack_q &&
    avs_address_i == REG_ENCAP && cls_q == CLS_IP |=>
    avs_readdata_o[ENC_VALID_BIT] == (code_q == 8'h04))
    else $error("ip encapsulation check wrong");
  module_code_a: assert property (avs_read_i && !ack_q &&
    avs_address_i == REG_ENCAP && cls_q == CLS_MODULE |=>
    avs_readdata_o[ENC_VALID_BIT] == (code_q == 8'h01))
    else $error("module encapsulation check wrong");
  carousel_code_a: assert property (avs_read_i && !ack_q &&
    avs_address_i == REG_ENCAP && cls_q == CLS_CAROUSEL |=>
    avs_readdata_o[ENC_VALID_BIT] == (code_q == 8'h0d))
    else $error("carousel encapsulation check wrong");
  stream_code_a: assert property (avs_read_i && !ack_q &&
    avs_address_i == REG_ENCAP && cls_q == CLS_STREAM |=>
    avs_readdata_o[ENC_VALID_BIT] ==
    (code_q == 8'h01 || code_q == 8'h0b))
    else $error("stream encapsulation check wrong");
  model_mism_a: assert property (mism_set |=> mism_q ##1 mism_q)
    else $error("model mismatch not held");
  bad_frame_a: assert property (take && endbyte && (bad || end_bad) |=>
    out_o.valid && out_o.last && out_o.err ##1 err_q)
    else $error("bad frame not flagged");
  tag_err_a: assert property (take && st_q == ST_TAG && b != 8'hae |=>
    ferr_q && st_q == ST_WLEN)
    else $error("wrong tag not flagged");
endmodule

// File: dse_mux_model.sv
// multiplexer-side model that streams compatibility wrapper frames
module dse_mux_model
  import dse_pkg::*;
#(
  parameter logic [23:0] OUI = 24'h00a5a5  // value is arbitrary
) (
  // clock
  input  wire logic clk_i,
  // byte stream toward the block
  output dse_in_s   in_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] fr_q[$];

  // fields outside the wrapper frames; this sender never writes them
  localparam logic [31:0] STREAM_MOD_SIZE  = 32'h0000_0000;
  localparam bit          SEND_SERVER_INIT = 1'b0;
  localparam logic [7:0]  TRIG_KIND        = 8'h00;
  localparam logic [7:0]  TRIG_TGT_KIND    = 8'h00;
  localparam logic [7:0]  TRIG_TGT_LEN     = 8'h00;
  localparam logic [7:0]  SOLE_IDENT_LEN   = 8'h00;
  localparam logic [15:0] SHARED_IDENT_LEN = 16'h0012;
  localparam logic [15:0] SHARED_DESC      = 16'h0000;

  // event trigger user data length is the payload byte count
  function automatic logic [7:0] user_len(input int n);
    user_len = 8'(n);
  endfunction

  initial in_o = '0;

  // idx < 0 sends a clean frame, else byte idx is replaced by val
  task automatic send(input int idx, input logic [7:0] val, input bit gap);
    logic [7:0] last_b;
    last_b = 8'h00;
    fr_q = {WRAP_TAG, 8'h0f,
            8'h00, 8'h0d, 8'h00, 8'h01,
            KIND_SYSSW, FIRST_LEN, SPEC_OUI,
            OUI[23:16], OUI[15:8], OUI[7:0],
            8'h12, 8'h34, 8'h56, 8'h78, 8'h00};
    if (idx >= 0) fr_q[idx] = val;
    foreach (fr_q[i]) begin
      in_o <= '{valid: 1'b1, data: fr_q[i]};
      last_b = fr_q[i];
      @(posedge clk_i);
      if (gap) begin
        // idle data toggles so a stale byte is never mistaken for valid
        in_o <= '{valid: 1'b0, data: ~last_b};
        @(posedge clk_i);
      end
    end
    in_o <= '{valid: 1'b0, data: ~last_b};
  endtask
endmodule

// File: dse_pkg.sv
// shared constants and types of the encapsulation formatter
package dse_pkg;
  // encapsulation codes
  localparam logic [7:0] ENC_IP       = 8'h04;
  localparam logic [7:0] ENC_DOWNLOAD = 8'h01;
  localparam logic [7:0] ENC_CAROUSEL = 8'h0d;
  localparam logic [7:0] ENC_PIPE     = 8'h0b;
  // fixed descriptor fields
  localparam logic [7:0]  WRAP_TAG     = 8'hae;
  localparam logic [15:0] TOTAL_MAX    = 16'h00fd;
  localparam logic [15:0] TOTAL_HDR    = 16'h0002;
  localparam logic [7:0]  KIND_SYSSW   = 8'h02;
  localparam logic [7:0]  SPEC_OUI     = 8'h01;
  localparam logic [7:0]  FIRST_LEN    = 8'h09;
  // register byte offsets
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_ENCAP   = 5'h04;
  localparam logic [4:0] REG_STATUS  = 5'h08;
  localparam logic [4:0] REG_MODEL   = 5'h0c;
  localparam logic [4:0] REG_VERSION = 5'h10;
  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int ENC_VALID_BIT = 16;
  localparam int ST_ERR_BIT    = 0;
  localparam int ST_MISM_BIT   = 1;
  // reset values
  localparam logic [15:0] MODEL_RST = 16'h0000;
  localparam logic        EN_RST    = 1'b1;

  typedef enum logic [1:0] {
    CLS_IP       = 2'h0,
    CLS_MODULE   = 2'h1,
    CLS_CAROUSEL = 2'h2,
    CLS_STREAM   = 2'h3
  } dse_class_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dse_in_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       err;
  } dse_out_s;
endpackage

// File: testbench.sv
// self-checking bench of the encapsulation formatter
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench
  import dse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [23:0] OUI = 24'h00a5a5;  // value is arbitrary

  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [4:0]  avs_address_i = '0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] ex;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  dse_in_s     in_i;
  logic        in_ready_o;
  dse_out_s    out_o;
  dse_out_s    cap_q[$];
  logic [31:0] rd;
  int          errors = 0;
  int          n_compared = 0;

  typedef struct {logic [1:0] c; logic [7:0] code; logic v; logic [7:0] x;}
    dse_row_s;
  dse_row_s rows[7] = '{'{0, 8'h04, 1, 8'h04}, '{1, 8'h01, 1, 8'h01},
    '{2, 8'h0d, 1, 8'h0d}, '{3, 8'h01, 1, 8'h01}, '{3, 8'h0b, 1, 8'h01},
    '{3, 8'h0d, 0, 8'h01}, '{1, 8'h0d, 0, 8'h01}};
  int         ci[7] = '{6, 8, 16, 3, 5, 7, 0};
  logic [7:0] cv[7] = '{8'h03, 8'h02, 8'h01, 8'h0e, 8'h02, 8'h0a, 8'h5a};

  always #50 clk_i = ~clk_i;

  dse_formatter #(.OWN_OUI(OUI)) dut_u (
    .clk_i            (clk_i),
    .rstn_i           (rstn_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .in_i             (in_i),
    .in_ready_o       (in_ready_o),
    .out_o            (out_o)
  );

  dse_mux_model #(.OUI(OUI)) partner_u (
    .clk_i(clk_i),
    .in_o (in_i)
  );

  always @(posedge clk_i) begin
    if (out_o.valid === 1'b1) cap_q.push_back(out_o);
  end

  // one bus access; request held until waitrequest is seen low
  task automatic xfer(input bit w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    if (w) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    // waitrequest and read data are both taken at one rising edge
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run(input int idx, input logic [7:0] val, input bit gap,
                     input logic ex_err, input bit en);
    int m;
    cap_q.delete();
    partner_u.send(idx, val, gap);
    repeat (3) @(posedge clk_i);
    m = en ? partner_u.fr_q.size() - 2 : 0;
    `CHK("out count", m, cap_q.size())
    foreach (cap_q[i]) begin
      `CHK("out byte", partner_u.fr_q[i + 2], cap_q[i].data)
      `CHK("out last", (i == m - 1), cap_q[i].last)
      `CHK("out err", (i == m - 1) & ex_err, cap_q[i].err)
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #3000000;
    errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    `CHK("out idle", 12'h000, out_o)
    `CHK("in ready", 1'b1, in_ready_o)
    xfer(0, REG_CTRL, '0);
    `CHK("ctrl rst", EN_RST, rd[CTRL_EN_BIT])
    xfer(0, REG_MODEL, '0);
    `CHK("model rst", MODEL_RST, rd[15:0])
    xfer(0, 5'h14, '0);
    `CHK("unmapped", 32'h0, rd)
    foreach (rows[i]) begin
      xfer(1, REG_ENCAP, {16'h0, rows[i].code, 6'h0, rows[i].c});
      xfer(0, REG_ENCAP, '0);
      ex = {rows[i].x, 7'h0, rows[i].v, rows[i].code, 6'h0, rows[i].c};
      `CHK("encap", ex, rd)
    end
    // clean frame, back to back bytes; expected model still zero
    run(-1, 8'h00, 0, 1'b0, 1);
    xfer(0, REG_STATUS, '0);
    `CHK("status good", 24'h000102, rd[23:0])
    xfer(0, REG_MODEL, '0);
    `CHK("model seen", 16'h1234, rd[31:16])
    xfer(0, REG_VERSION, '0);
    `CHK("version", 16'h5678, rd[15:0])
    xfer(1, REG_MODEL, 32'h0000_1234);
    xfer(1, REG_STATUS, 32'h3);
    xfer(0, REG_STATUS, '0);
    `CHK("w1c", 2'b00, rd[1:0])
    // one broken field per frame, gapped and back to back alternately
    foreach (ci[i]) begin
      run(ci[i], cv[i], i[0], 1'b1, 1);
    end
    xfer(0, REG_STATUS, '0);
    `CHK("status bad", 24'h070801, rd[23:0])
    run(-1, 8'h00, 1, 1'b0, 1);
    xfer(1, REG_STATUS, 32'h1);
    xfer(0, REG_STATUS, '0);
    `CHK("status end", 24'h070900, rd[23:0])
    // disabled parser drops the whole frame
    xfer(1, REG_CTRL, 32'h0);
    run(-1, 8'h00, 0, 1'b0, 0);
    xfer(0, REG_STATUS, '0);
    `CHK("drop count", 8'h09, rd[15:8])
    // only the upper byte of the expected model is enabled
    avs_byteenable_i <= 4'h2;
    xfer(1, REG_MODEL, 32'h0000_ff99);
    avs_byteenable_i <= 4'hf;
    xfer(0, REG_MODEL, '0);
    `CHK("model be", 32'h1234_ff34, rd)
    print_verdict();
  end
endmodule
